// >>> rtl/irq_enable_pkg.sv
// Shared constants for the interrupt enable-clear block
package irq_enable_pkg;
	// Register byte addresses
	localparam logic [7:0] ADDR_ENABLE_CLEAR = 8'h00;
	localparam logic [7:0] ADDR_ENABLE_SET = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_MASK = 8'h0c;
	localparam logic [7:0] ADDR_CONTROL = 8'h10;
	// Source bit positions inside every per-source register
	localparam int BIT_IDENT = 13;
	localparam int BIT_RECEIVER = 9;
	localparam int BIT_TRANSMITTER = 8;
	localparam int BIT_TRIPLE_WAKE = 7;
	localparam int BIT_SINGLE_WAKE = 6;
	localparam int BIT_BUS_IDLE = 4;
	localparam int BIT_WAKE = 1;
	// Control register fields
	localparam int BIT_LIN_MODE = 0;
	localparam int BIT_PROTECTED = 1;
	// Implemented source bits; everything else reads zero
	localparam logic [31:0] IMPL_MASK = 32'h0000_23d2;
	// Sources that only exist in LIN mode
	localparam logic [31:0] LIN_ONLY_MASK = 32'h0000_20d0;
	// Reserved positions named by the field table
	localparam logic [31:0] RESERVED_MASK = 32'h0000_1c20;
	// Reset values
	localparam logic [31:0] ENABLE_RESET = 32'h0000_0000;
	localparam logic [31:0] MASK_RESET = 32'h0000_0000;
	localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
	// Bus response codes
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> rtl/reg_access_if.sv
// Register access strobes between the bus front end and the register core
`timescale 1ns/1ps
`default_nettype none
interface reg_access_if;
	logic wrEn; // One-cycle write pulse
	logic [7:0] wrAddr; // Write byte address
	logic [31:0] wrData; // Write data
	logic [3:0] wrStrb; // Write byte lanes
	logic rdEn; // One-cycle read pulse, side effects fire with it
	logic [7:0] rdAddr; // Read byte address
	logic [31:0] rdData; // Read data, valid while rdEn
	logic rdErr; // Read address unmapped
	logic wrErr; // Write address unmapped
	modport bus (output wrEn, wrAddr, wrData, wrStrb, rdEn, rdAddr, input rdData, rdErr, wrErr);
	modport core (input wrEn, wrAddr, wrData, wrStrb, rdEn, rdAddr, output rdData, rdErr, wrErr);
endinterface
`default_nettype wire

// >>> rtl/axil_reg_slave.sv
// AXI4-Lite slave front end turning bus beats into register strobes
`timescale 1ns/1ps
`default_nettype none
module axil_reg_slave (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Write channels
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// Read channels
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Register side
	reg_access_if.bus rg
);
	// All bus-facing state in one record
	typedef struct packed {
		logic wrReady;
		logic bValid;
		logic [1:0] bResp;
		logic rdReady;
		logic rValid;
		logic [1:0] rResp;
		logic [31:0] rData;
	} slave_t;
	slave_t s_q, s_d;

	// Strobes are combinational on the ready pulse; valid is held by the master
	assign rg.wrEn = s_q.wrReady & awvalid & wvalid;
	assign rg.wrAddr = awaddr;
	assign rg.wrData = wdata;
	assign rg.wrStrb = wstrb;
	assign rg.rdEn = s_q.rdReady & arvalid;
	assign rg.rdAddr = araddr;

	// Next state; both write channels are taken together, so either order works
	always_comb
	begin
		s_d = s_q;
		s_d.wrReady = awvalid & wvalid & ~s_q.wrReady & ~s_q.bValid;
		s_d.rdReady = arvalid & ~s_q.rdReady & ~s_q.rValid;
		if (s_q.bValid & bready)
			s_d.bValid = 1'b0;
		if (rg.wrEn)
		begin
			s_d.bValid = 1'b1;
			s_d.bResp = rg.wrErr ? irq_enable_pkg::RESP_SLVERR : irq_enable_pkg::RESP_OKAY;
		end
		if (s_q.rValid & rready)
			s_d.rValid = 1'b0;
		if (rg.rdEn)
		begin
			s_d.rValid = 1'b1;
			s_d.rData = rg.rdData;
			s_d.rResp = rg.rdErr ? irq_enable_pkg::RESP_SLVERR : irq_enable_pkg::RESP_OKAY;
		end
	end

	// State register
	always_ff @(posedge clk)
	begin
		if (!resetn)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	// Outputs straight from flops
	assign awready = s_q.wrReady;
	assign wready = s_q.wrReady;
	assign bvalid = s_q.bValid;
	assign bresp = s_q.bResp;
	assign arready = s_q.rdReady;
	assign rvalid = s_q.rValid;
	assign rresp = s_q.rResp;
	assign rdata = s_q.rData;
endmodule
`default_nettype wire

// >>> rtl/lin_irq_enable_clear_low.sv
// Interrupt enable-clear register block with status, mask and level output
//
// How it works
// (R01) Writing one to bit 13 disables identifier source
// (R02) Enable bits read one enabled, zero disabled
// (R03) Written zero keeps enable, one clears it
// (R04) Reserved bits 12-10, 5 read zero, ignore writes
// (R05) Bit 9 disables receiver, only in protected mode
// (R06) Bit 8 disables transmitter, reads back there
// (R07) Bit 7 disables triple-wake timeout, LIN only
// (R08) Bit 6 disables single-wake timeout, LIN only
// (R09) Bus-idle bit disables bus idle timeout source
// (R10) Wake bit disables wake source, reads back
// (R11) Disabled sources raise no interrupt request
//
// Design decisions made here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module lin_irq_enable_clear_low (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// AXI4-Lite write channels
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read channels
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Source event pulses from the controller, same clock
	input wire logic identEvent,
	input wire logic receiverEvent,
	input wire logic transmitterEvent,
	input wire logic tripleWakeEvent,
	input wire logic singleWakeEvent,
	input wire logic busIdleEvent,
	input wire logic wakeEvent,
	// Interrupt outputs
	output logic [31:0] sourceRequest,
	output logic irq
);
	// Whole block state in one record
	typedef struct packed {
		logic [31:0] enable;
		logic [31:0] mask;
		logic [31:0] status;
		logic linMode;
		logic protMode;
		logic [31:0] request;
		logic irq;
	} core_t;
	core_t st_q, st_d;

	// Register strobes from the bus front end
	reg_access_if rg ();

	// Bus front end
	axil_reg_slave busSlave (
		.clk(clk),
		.resetn(resetn),
		.awaddr(awaddr),
		.awvalid(awvalid),
		.awready(awready),
		.wdata(wdata),
		.wstrb(wstrb),
		.wvalid(wvalid),
		.wready(wready),
		.bresp(bresp),
		.bvalid(bvalid),
		.bready(bready),
		.araddr(araddr),
		.arvalid(arvalid),
		.arready(arready),
		.rdata(rdata),
		.rresp(rresp),
		.rvalid(rvalid),
		.rready(rready),
		.rg(rg)
	);

	// Expand byte strobes into a bit mask
	function automatic logic [31:0] laneMask(input logic [3:0] strb);
		laneMask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
	endfunction

	// True when an address names one of our registers
	function automatic logic isMapped(input logic [7:0] addr);
		isMapped = (addr == irq_enable_pkg::ADDR_ENABLE_CLEAR) || (addr == irq_enable_pkg::ADDR_ENABLE_SET)
			|| (addr == irq_enable_pkg::ADDR_STATUS) || (addr == irq_enable_pkg::ADDR_MASK)
			|| (addr == irq_enable_pkg::ADDR_CONTROL);
	endfunction

	// Written ones limited to enabled lanes and implemented sources
	logic [31:0] wrBits;
	assign wrBits = rg.wrData & laneMask(rg.wrStrb) & irq_enable_pkg::IMPL_MASK; // see R04

	// Decoded write strobes
	logic wrClear;
	logic wrSet;
	logic wrMask;
	logic wrCtrl;
	assign wrClear = rg.wrEn && rg.wrAddr == irq_enable_pkg::ADDR_ENABLE_CLEAR;
	assign wrSet = rg.wrEn && rg.wrAddr == irq_enable_pkg::ADDR_ENABLE_SET;
	assign wrMask = rg.wrEn && rg.wrAddr == irq_enable_pkg::ADDR_MASK;
	assign wrCtrl = rg.wrEn && rg.wrAddr == irq_enable_pkg::ADDR_CONTROL;

	// Receiver disable only takes effect in protected-write mode
	logic [31:0] clearBits;
	always_comb
	begin
		clearBits = wrBits; // see R03
		if (!st_q.protMode)
			clearBits[irq_enable_pkg::BIT_RECEIVER] = 1'b0; // see R05
	end

	// Raw events placed at their source positions
	logic [31:0] eventBits;
	always_comb
	begin
		eventBits = irq_enable_pkg::ZERO_WORD;
		eventBits[irq_enable_pkg::BIT_IDENT] = identEvent;
		eventBits[irq_enable_pkg::BIT_RECEIVER] = receiverEvent;
		eventBits[irq_enable_pkg::BIT_TRANSMITTER] = transmitterEvent;
		eventBits[irq_enable_pkg::BIT_TRIPLE_WAKE] = tripleWakeEvent;
		eventBits[irq_enable_pkg::BIT_SINGLE_WAKE] = singleWakeEvent;
		eventBits[irq_enable_pkg::BIT_BUS_IDLE] = busIdleEvent;
		eventBits[irq_enable_pkg::BIT_WAKE] = wakeEvent;
		// LIN-only sources cannot fire outside LIN mode
		if (!st_q.linMode)
			eventBits = eventBits & ~irq_enable_pkg::LIN_ONLY_MASK; // see R07 R08 R09
	end

	// Read mux; unmapped addresses answer with an error and zero data
	logic statusRead;
	assign statusRead = rg.rdEn && rg.rdAddr == irq_enable_pkg::ADDR_STATUS;
	always_comb
	begin
		rg.rdData = irq_enable_pkg::ZERO_WORD;
		case (rg.rdAddr)
			irq_enable_pkg::ADDR_ENABLE_CLEAR: rg.rdData = st_q.enable & irq_enable_pkg::IMPL_MASK; // see R02 R04
			irq_enable_pkg::ADDR_ENABLE_SET: rg.rdData = st_q.enable & irq_enable_pkg::IMPL_MASK;
			irq_enable_pkg::ADDR_STATUS: rg.rdData = st_q.status;
			irq_enable_pkg::ADDR_MASK: rg.rdData = st_q.mask;
			irq_enable_pkg::ADDR_CONTROL:
			begin
				rg.rdData[irq_enable_pkg::BIT_LIN_MODE] = st_q.linMode;
				rg.rdData[irq_enable_pkg::BIT_PROTECTED] = st_q.protMode;
			end
			default: rg.rdData = irq_enable_pkg::ZERO_WORD;
		endcase
	end
	assign rg.rdErr = !isMapped(rg.rdAddr);
	assign rg.wrErr = !isMapped(rg.wrAddr);

	// Next-state logic for the whole block
	always_comb
	begin
		st_d = st_q;
		// Ones disable sources; zeros leave them alone
		if (wrClear)
			st_d.enable = st_q.enable & ~clearBits; // see R01 R03 R06 R07 R08 R09 R10
		// Companion path so software can re-enable a source
		if (wrSet)
			st_d.enable = st_q.enable | wrBits;
		if (wrMask)
			st_d.mask = (st_q.mask & ~laneMask(rg.wrStrb)) | wrBits;
		if (wrCtrl && rg.wrStrb[0])
		begin
			st_d.linMode = rg.wrData[irq_enable_pkg::BIT_LIN_MODE];
			st_d.protMode = rg.wrData[irq_enable_pkg::BIT_PROTECTED];
		end
		// Read clears status, but a same-cycle event still lands
		st_d.status = (statusRead ? irq_enable_pkg::ZERO_WORD : st_q.status) | eventBits;
		// Gate each pending source with its enable before the request and irq outputs see it
		st_d.request = st_q.status & st_q.enable; // see R11
		st_d.irq = |(st_q.status & st_q.enable & st_q.mask); // see R11
	end

	// State register, synchronous reset
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			st_q <= '0;
			st_q.enable <= irq_enable_pkg::ENABLE_RESET;
			st_q.mask <= irq_enable_pkg::MASK_RESET;
		end
		else
			st_q <= st_d;
	end

	// Outputs from flops
	assign sourceRequest = st_q.request;
	assign irq = st_q.irq;

	// Checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	// Plain write data after byte lanes, for the checks
	logic [31:0] wrLanes;
	assign wrLanes = rg.wrData & laneMask(rg.wrStrb);

	chk_ident_clear: assert property (wrClear && wrLanes[13] |=> !st_q.enable[13]) // see R01
		else $error("identifier source still enabled after clear");
	chk_readback_value: assert property (rg.rdEn && rg.rdAddr == irq_enable_pkg::ADDR_ENABLE_CLEAR
		|-> rg.rdData == (st_q.enable & irq_enable_pkg::IMPL_MASK)) // see R02
		else $error("enable readback differs from enable state");
	chk_zero_keeps: assert property (wrClear |=> (st_q.enable & ~$past(wrLanes) & irq_enable_pkg::IMPL_MASK)
		== ($past(st_q.enable) & ~$past(wrLanes) & irq_enable_pkg::IMPL_MASK)) // see R03
		else $error("zero write changed an enable");
	chk_reserved_zero: assert property ((st_q.enable & irq_enable_pkg::RESERVED_MASK) == irq_enable_pkg::ZERO_WORD
		&& !(rg.rdEn && rg.rdAddr == irq_enable_pkg::ADDR_ENABLE_CLEAR
		&& (rg.rdData & irq_enable_pkg::RESERVED_MASK) != irq_enable_pkg::ZERO_WORD)) // see R04
		else $error("reserved bit set or read as one");
	chk_rx_protected: assert property (wrClear && wrLanes[9] && !st_q.protMode && !wrSet
		|=> st_q.enable[9] == $past(st_q.enable[9])) // see R05
		else $error("receiver disabled outside protected mode");
	chk_rx_clear: assert property (wrClear && wrLanes[9] && st_q.protMode |=> !st_q.enable[9]) // see R05
		else $error("receiver not disabled in protected mode");
	chk_tx_clear: assert property (wrClear && wrLanes[8] |=> !st_q.enable[8]) // see R06
		else $error("transmitter enable still set after clear");
	chk_triple_clear: assert property (wrClear && wrLanes[7] |=> !st_q.enable[7]) // see R07
		else $error("triple wake source still enabled");
	chk_single_clear: assert property (wrClear && wrLanes[6] |=> !st_q.enable[6]) // see R08
		else $error("single wake source still enabled");
	chk_idle_clear: assert property (wrClear && wrLanes[4] |=> !st_q.enable[4]) // see R09
		else $error("bus idle source still enabled");
	chk_wake_clear: assert property (wrClear && wrLanes[1] |=> !st_q.enable[1]) // see R10
		else $error("wake source still enabled after clear");
	chk_disabled_quiet: assert property (!st_q.enable[13] && !wrSet |=> !st_q.request[13]) // see R11
		else $error("disabled identifier source requests");
	chk_irq_level: assert property (st_q.status[1] && st_q.enable[1] && st_q.mask[1] |=> irq) // see R11
		else $error("enabled unmasked wake pending but no interrupt");

	// Main scenarios
	cov_clear_write: cover property (wrClear && wrLanes[13]);
	cov_irq_raised: cover property ($rose(irq));
	cov_status_read: cover property (statusRead && st_q.status != irq_enable_pkg::ZERO_WORD);
	cov_rx_blocked: cover property (wrClear && wrLanes[9] && !st_q.protMode);
endmodule
`default_nettype wire

// >>> sim/lin_irq_enable_clear_low_tb.sv
// Self-checking testbench for the interrupt enable-clear register block
`timescale 1ns/1ps
`default_nettype none
module lin_irq_enable_clear_low_tb;
	// Short local names for the register map
	localparam logic [7:0] A_CLR = irq_enable_pkg::ADDR_ENABLE_CLEAR;
	localparam logic [7:0] A_SET = irq_enable_pkg::ADDR_ENABLE_SET;
	localparam logic [7:0] A_STAT = irq_enable_pkg::ADDR_STATUS;
	localparam logic [7:0] A_MASK = irq_enable_pkg::ADDR_MASK;
	localparam logic [7:0] A_CTRL = irq_enable_pkg::ADDR_CONTROL;
	localparam logic [1:0] OK = irq_enable_pkg::RESP_OKAY;
	localparam logic [1:0] ERR = irq_enable_pkg::RESP_SLVERR;
	// Source bit of each event input, same order as the event vector
	localparam int SRC_BIT [7] = '{13, 9, 8, 7, 6, 4, 1};
	// Bus, event and result signals
	logic clk;
	logic resetn;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, sourceRequest;
	logic [3:0] wstrb;
	logic awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0] bresp, rresp;
	logic [6:0] ev; // One pulse line per source
	int mismatches, checked, cycles;

	lin_irq_enable_clear_low dut (.clk(clk), .resetn(resetn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.identEvent(ev[0]), .receiverEvent(ev[1]), .transmitterEvent(ev[2]),
		.tripleWakeEvent(ev[3]), .singleWakeEvent(ev[4]), .busIdleEvent(ev[5]),
		.wakeEvent(ev[6]), .sourceRequest(sourceRequest), .irq(irq));

	// Verdict, reached from the main sequence or the timeout
	task automatic wrap_up;
		$display("checked=%0d mismatches=%0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Word compare, also used for response codes
	task automatic cmpWord(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Single flag compare
	task automatic cmpBit(input logic got, input logic exp);
		checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Write: address and data offered together, each released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic awDone, wDone;
		awDone = 1'h0;
		wDone = 1'h0;
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		while (!(awDone && wDone))
		begin
			@(posedge clk);
			if (awready === 1'h1 && !awDone)
			begin
				awvalid <= 1'h0;
				awDone = 1'h1;
			end
			if (wready === 1'h1 && !wDone)
			begin
				wvalid <= 1'h0;
				wDone = 1'h1;
			end
		end
		// Response only counts at an edge with bready high
		do @(posedge clk); while (bvalid !== 1'h1);
		bready <= 1'h0;
		cmpWord({30'h0, bresp}, {30'h0, er});
		@(posedge clk);
	endtask

	// Read: address held until taken, data judged at the rvalid edge
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do @(posedge clk); while (arready !== 1'h1);
		arvalid <= 1'h0;
		do @(posedge clk); while (rvalid !== 1'h1);
		rready <= 1'h0;
		cmpWord(rdata, e);
		cmpWord({30'h0, rresp}, {30'h0, er});
		@(posedge clk);
	endtask

	// One-cycle event; request shows one edge after status, sampled after that
	task automatic pulse(input int i);
		ev[i] <= 1'h1;
		@(posedge clk);
		ev <= 7'h0;
		repeat (2) @(posedge clk);
	endtask

	// Everything disabled and quiet out of reset
	task automatic resetScenario;
		rd(A_CLR, 32'h0, OK);
		rd(A_STAT, 32'h0, OK);
		cmpWord(sourceRequest, 32'h0);
		cmpBit(irq, 1'h0);
	endtask

	// Write-one-to-disable per source, zeros and reserved bits inert
	task automatic clearScenario;
		logic [31:0] exp;
		wr(A_CTRL, 32'h1, OK); // LIN mode, unprotected
		wr(A_SET, 32'hffff_ffff, OK);
		exp = irq_enable_pkg::IMPL_MASK;
		rd(A_CLR, exp, OK);
		wr(A_CLR, 32'h0, OK);
		rd(A_CLR, exp, OK);
		wr(A_CLR, 32'h0000_1c20, OK);
		rd(A_CLR, exp, OK);
		for (int i = 0; i < 7; i++)
		begin
			wr(A_CLR, 32'h1 << SRC_BIT[i], OK);
			// Receiver disable needs the protected mode, so it holds here
			if (SRC_BIT[i] != 9)
				exp = exp & ~(32'h1 << SRC_BIT[i]);
			rd(A_CLR, exp, OK);
		end
		wr(A_CTRL, 32'h3, OK);
		wr(A_CLR, 32'h0000_0200, OK);
		rd(A_CLR, 32'h0, OK);
	endtask

	// Enabled sources raise a request; disabled ones stay silent
	task automatic gateScenario;
		logic [31:0] b;
		wr(A_SET, irq_enable_pkg::IMPL_MASK, OK);
		wr(A_MASK, irq_enable_pkg::IMPL_MASK, OK);
		for (int i = 0; i < 7; i++)
		begin
			b = 32'h1 << SRC_BIT[i];
			pulse(i);
			cmpWord(sourceRequest, b);
			cmpBit(irq, 1'h1);
			rd(A_STAT, b, OK);
			wr(A_CLR, b, OK);
			pulse(i);
			cmpWord(sourceRequest, 32'h0);
			cmpBit(irq, 1'h0);
			rd(A_STAT, b, OK);
		end
		// Masked source still shows its request but leaves the line low
		wr(A_SET, 32'h2, OK);
		wr(A_MASK, 32'h0, OK);
		pulse(6);
		cmpWord(sourceRequest, 32'h2);
		cmpBit(irq, 1'h0);
		rd(A_STAT, 32'h2, OK);
	endtask

	// Outside LIN mode the LIN-only sources stay silent, the receiver still fires
	task automatic linOffScenario;
		wr(A_CTRL, 32'h0, OK);
		wr(A_SET, irq_enable_pkg::IMPL_MASK, OK);
		pulse(0);
		cmpWord(sourceRequest, 32'h0);
		pulse(5);
		cmpWord(sourceRequest, 32'h0);
		rd(A_STAT, 32'h0, OK);
		pulse(1);
		cmpWord(sourceRequest, 32'h0000_0200);
		rd(A_STAT, 32'h0000_0200, OK);
	endtask

	// Unmapped address answers with an error and touches nothing
	task automatic unmappedScenario;
		wr(8'h20, 32'hffff_ffff, ERR);
		rd(8'h20, 32'h0, ERR);
		rd(A_CLR, 32'h2, OK);
	endtask

	// Free-running clock
	initial
	begin
		clk = 1'h0;
		forever #20 clk = ~clk;
	end

	// Hang guard, well above the few hundred cycles needed
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			mismatches++;
			wrap_up();
		end
	end

	// Main sequence
	initial
	begin
		resetn = 1'h0;
		{awaddr, araddr, wdata, wstrb, ev} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		mismatches = 0;
		checked = 0;
		cycles = 0;
		repeat (3) @(posedge clk);
		resetn <= 1'h1;
		@(posedge clk);
		resetScenario();
		clearScenario();
		gateScenario();
		unmappedScenario();
		linOffScenario();
		wrap_up();
	end
endmodule
`default_nettype wire
